// file: pjm_probe_pin_mux.sv
// What this block does
// R1 - Scan port shifts net selection; probes show it
// R2 - Dedicated: scan pins reserved, TMS/TDI pull-ups on
// R3 - Flexible: scan pins user I/O, pull-ups off
// R4 - Flexible: TCK rise with TMS low claims pins
// R5 - Flexible: Test-Logic-Reset returns pins to user
// R6 - Secured: probe off, checksum still readable
// R7 - Mode/TMS low user I/O; high probes unless secured
// R8 - Mode pin high or part unprogrammed: aux pins inputs only
// R9 - Four probe outputs, or two on smallest part
// R10 - Test reset held high during scan and probing
module pjm_probe_pin_mux
#(
   parameter int NUM_PROBES = pjm_pkg::PROBES_DEF,
   parameter int SEL_W = pjm_pkg::SEL_W_DEF,
   parameter int CK_W = pjm_pkg::CK_W_DEF,
   parameter bit MODE_PIN_FAMILY = 1'b0
)
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic scan_clk_i,
   input wire logic trst_n_i,
   input wire logic cfg_dedicated_i,
   input wire logic fuse_secure_i,
   input wire logic part_programmed_i,
   input wire logic mode_sel_i,
   input wire logic tms_i,
   input wire logic [2:0] scan_pin_i,
   output logic [2:0] scan_pin_o,
   output logic [2:0] scan_pin_oe_o,
   input wire logic [NUM_PROBES-1:0] probe_out_i,
   output logic [NUM_PROBES-1:0] probe_out_o,
   output logic [NUM_PROBES-1:0] probe_out_oe_o,
   input wire logic [1:0] probe_aux_i,
   output logic [1:0] probe_aux_o,
   output logic [1:0] probe_aux_oe_o,
   output logic checksum_serial_out_o,
   output logic tms_pullup_en_o,
   output logic tdi_pullup_en_o,
   input wire logic [(1<<SEL_W)-1:0] probe_nets_i,
   input wire logic [CK_W-1:0] checksum_i,
   input wire pjm_pkg::pjm_scan_drv_t user_scan_i,
   input wire pjm_pkg::pjm_probe_drv_t user_probe_i,
   input wire pjm_pkg::pjm_aux_drv_t user_aux_i,
   output logic [2:0] user_scan_in_o,
   output logic [NUM_PROBES-1:0] user_probe_in_o,
   output logic [1:0] user_aux_in_o,
   output pjm_pkg::pjm_status_t status_o
);
   import pjm_pkg::*;

   localparam int SEL_TOT = NUM_PROBES * SEL_W;
   localparam int SW = NUM_PROBES + 13;
   localparam int CNT_W = $clog2(SEL_TOT + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SEL_TOT - 1);

   // ----------------------------------------------------------------
   // Scan clock domain
   // ----------------------------------------------------------------
   logic tap_rst;
   pjm_tap_t tap_st;
   logic [2:0] t_meta;
   logic [2:0] t_sync;
   logic ded_t;
   logic fuse_t;
   logic mode_t;
   logic scan_active;
   logic [IR_W-1:0] ir_sh;
   logic [IR_W-1:0] ir;
   logic bypass_q;
   logic [SEL_TOT-1:0] sel_sh;
   logic [SEL_TOT-1:0] next_sel_sh;
   logic [SEL_TOT-1:0] sel_hold;
   logic [CK_W-1:0] ck_sh;
   logic [CNT_W-1:0] mf_cnt;
   logic mf_shift;
   logic upd_tgl;
   logic tdo_q;
   logic tdo_en_q;

   // Test reset pin clears the port asynchronously
   assign tap_rst = rst_i | ~trst_n_i; // R10

   pjm_tap_fsm u_tap
   (
      .clk_i(scan_clk_i),
      .rst_i(tap_rst),
      .tms_i(tms_i),
      .state_o(tap_st)
   );

   always_ff @(posedge scan_clk_i or posedge tap_rst)
   begin
      if (tap_rst)
      begin
         t_meta <= 3'h0;
         t_sync <= 3'h0;
      end
      else
      begin
         t_meta <= {cfg_dedicated_i, fuse_secure_i, mode_sel_i};
         t_sync <= t_meta;
      end
   end

   assign ded_t = t_sync[2];
   assign fuse_t = t_sync[1];
   assign mode_t = t_sync[0];

   // Flexible pins are claimed on a TCK rise with TMS low and freed in reset state
   always_ff @(posedge scan_clk_i or posedge tap_rst)
   begin
      if (tap_rst)
         scan_active <= SCAN_ACTIVE_RST;
      else if (ded_t || MODE_PIN_FAMILY)
         scan_active <= SCAN_ACTIVE_RST;
      else if (tap_st == TAP_RESET)
         scan_active <= ~tms_i; // R4 R5
      else if (!tms_i)
         scan_active <= 1'b1; // R4
   end

   always_ff @(posedge scan_clk_i or posedge tap_rst)
   begin
      if (tap_rst)
      begin
         ir_sh <= IR_RESET;
         ir <= IR_RESET;
      end
      else
      begin
         if (tap_st == TAP_CAP_IR)
            ir_sh <= IR_CAPTURE;
         else if (tap_st == TAP_SH_IR)
            ir_sh <= {scan_pin_i[PIN_TDI], ir_sh[IR_W-1:1]};
         if (tap_st == TAP_RESET)
            ir <= IR_RESET;
         else if (tap_st == TAP_UP_IR)
            ir <= ir_sh;
      end
   end

   // Checksum capture stays available when secured
   always_ff @(posedge scan_clk_i or posedge tap_rst)
   begin
      if (tap_rst)
      begin
         bypass_q <= 1'b0;
         ck_sh <= '0;
      end
      else if (tap_st == TAP_CAP_DR)
      begin
         bypass_q <= 1'b0;
         if (ir == IR_CHECKSUM)
            ck_sh <= checksum_i; // R6
      end
      else if (tap_st == TAP_SH_DR)
      begin
         bypass_q <= scan_pin_i[PIN_TDI];
         if (ir == IR_CHECKSUM)
            ck_sh <= {scan_pin_i[PIN_TDI], ck_sh[CK_W-1:1]}; // R6
      end
   end

   // Mode-pin parts shift the selection in on the aux serial pin
   assign mf_shift = MODE_PIN_FAMILY && mode_t && !fuse_t; // R8

   always_comb
   begin
      next_sel_sh = sel_sh;
      if (mf_shift)
         next_sel_sh = {probe_aux_i[AUX_SERIAL_IN], sel_sh[SEL_TOT-1:1]};
      else if (!MODE_PIN_FAMILY && tap_st == TAP_CAP_DR && ir == IR_PROBE)
         next_sel_sh = sel_hold;
      else if (!MODE_PIN_FAMILY && tap_st == TAP_SH_DR && ir == IR_PROBE)
         next_sel_sh = {scan_pin_i[PIN_TDI], sel_sh[SEL_TOT-1:1]}; // R1
   end

   always_ff @(posedge scan_clk_i or posedge tap_rst)
   begin
      if (tap_rst)
         sel_sh <= '0;
      else
         sel_sh <= next_sel_sh;
   end

   always_ff @(posedge scan_clk_i or posedge tap_rst)
   begin
      if (tap_rst)
         mf_cnt <= '0;
      else if (!mf_shift || mf_cnt == CNT_LAST)
         mf_cnt <= '0;
      else
         mf_cnt <= mf_cnt + 1'b1;
   end

   // Held copy stays still for the other domain; toggle marks each update
   always_ff @(posedge scan_clk_i or posedge tap_rst)
   begin
      if (tap_rst)
      begin
         sel_hold <= '0;
         upd_tgl <= 1'b0;
      end
      else if ((mf_shift && mf_cnt == CNT_LAST) ||
               (!MODE_PIN_FAMILY && !fuse_t && tap_st == TAP_UP_DR && ir == IR_PROBE))
      begin
         sel_hold <= next_sel_sh; // R1 R6
         upd_tgl <= ~upd_tgl;
      end
   end

   // Scan output changes on the falling edge
   always_ff @(negedge scan_clk_i or posedge tap_rst)
   begin
      if (tap_rst)
      begin
         tdo_q <= TDO_RST;
         tdo_en_q <= 1'b0;
      end
      else
      begin
         tdo_en_q <= (tap_st == TAP_SH_DR) || (tap_st == TAP_SH_IR);
         if (tap_st == TAP_SH_IR)
            tdo_q <= ir_sh[0];
         else if (ir == IR_CHECKSUM)
            tdo_q <= ck_sh[0]; // R6
         else if (ir == IR_PROBE)
            tdo_q <= sel_sh[0];
         else
            tdo_q <= bypass_q;
      end
   end

   // ----------------------------------------------------------------
   // System clock domain
   // ----------------------------------------------------------------
   logic [SW-1:0] raw;
   logic [SW-1:0] m_meta;
   logic [SW-1:0] m_sync;
   logic tms_m;
   logic [2:0] scan_m;
   logic [NUM_PROBES-1:0] probe_m;
   logic [1:0] aux_m;
   logic ded_m;
   logic fuse_m;
   logic prog_m;
   logic mode_m;
   logic trst_m;
   logic active_m;
   logic upd_m;
   logic upd_seen;
   logic [SEL_TOT-1:0] sel_m;
   logic [NUM_PROBES-1:0] probe_q;
   pjm_scan_drv_t scan_drv;
   pjm_probe_drv_t probe_drv;
   pjm_aux_drv_t aux_drv;
   logic scan_own_m;
   logic mode_level_m;
   logic probe_on_m;

   assign raw = {tms_i, scan_pin_i, probe_out_i, probe_aux_i, cfg_dedicated_i,
                 fuse_secure_i, part_programmed_i, mode_sel_i, trst_n_i,
                 scan_active, upd_tgl};

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         m_meta <= '0;
         m_sync <= '0;
      end
      else
      begin
         m_meta <= raw;
         m_sync <= m_meta;
      end
   end

   assign {tms_m, scan_m, probe_m, aux_m, ded_m, fuse_m, prog_m, mode_m, trst_m,
           active_m, upd_m} = m_sync;

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         user_scan_in_o <= 3'h0;
         user_probe_in_o <= '0;
         user_aux_in_o <= 2'h0;
         scan_drv <= '0;
         probe_drv <= '0;
         aux_drv <= '0;
      end
      else
      begin
         user_scan_in_o <= scan_m;
         user_probe_in_o <= probe_m;
         user_aux_in_o <= aux_m;
         scan_drv <= user_scan_i;
         probe_drv <= user_probe_i;
         aux_drv <= user_aux_i;
      end
   end

   // Copy the held selection once its toggle has crossed
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         upd_seen <= 1'b0;
         sel_m <= '0;
      end
      else
      begin
         upd_seen <= upd_m;
         if (upd_m != upd_seen)
            sel_m <= sel_hold; // R1
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         probe_q <= '0;
      else
         for (int k = 0; k < NUM_PROBES; k++)
            probe_q[k] <= probe_nets_i[sel_m[k*SEL_W +: SEL_W]]; // R1 R9
   end

   assign scan_own_m = ded_m | active_m; // R2 R3
   assign mode_level_m = MODE_PIN_FAMILY ? mode_m : tms_m;
   assign probe_on_m = mode_level_m & ~fuse_m & trst_m; // R6 R7 R10

   // ----------------------------------------------------------------
   // Pin function mux
   // ----------------------------------------------------------------
   always_comb
   begin
      scan_pin_o = scan_drv.o;
      scan_pin_oe_o = scan_drv.oe;
      if (scan_own_m || (!MODE_PIN_FAMILY && mode_level_m))
      begin
         scan_pin_o[PIN_TDI] = 1'b0; // R2 R4 R7
         scan_pin_oe_o[PIN_TDI] = 1'b0;
         scan_pin_o[PIN_TCK] = 1'b0;
         scan_pin_oe_o[PIN_TCK] = 1'b0;
      end
      if (scan_own_m)
      begin
         scan_pin_o[PIN_TDO] = tdo_q; // R2 R4
         scan_pin_oe_o[PIN_TDO] = tdo_en_q;
      end
   end

   always_comb
   begin
      for (int k = 0; k < NUM_PROBES; k++)
      begin
         if (probe_on_m)
         begin
            probe_out_o[k] = probe_q[k]; // R7
            probe_out_oe_o[k] = 1'b1;
         end
         else if (mode_level_m)
         begin
            probe_out_o[k] = 1'b0; // R6 R7
            probe_out_oe_o[k] = 1'b0;
         end
         else
         begin
            probe_out_o[k] = probe_drv.o[k]; // R7
            probe_out_oe_o[k] = probe_drv.oe[k];
         end
      end
   end

   always_comb
   begin
      probe_aux_o = aux_drv.o;
      probe_aux_oe_o = aux_drv.oe;
      if (mode_m || !prog_m)
      begin
         probe_aux_o = 2'h0; // R8
         probe_aux_oe_o = 2'h0;
      end
   end

   assign checksum_serial_out_o = tdo_q; // R6
   assign tms_pullup_en_o = ded_m; // R2 R3
   assign tdi_pullup_en_o = ded_m; // R2 R3

   always_comb
   begin
      status_o.scan_owns = scan_own_m;
      status_o.scan_active = active_m;
      status_o.probe_on = probe_on_m;
      status_o.secured = fuse_m;
   end

endmodule : pjm_probe_pin_mux

// file: pjm_pkg.sv
package pjm_pkg;

   // ----------------------------------------------------------------
   // Instruction register
   // ----------------------------------------------------------------
   localparam int IR_W = 2;
   localparam logic [IR_W-1:0] IR_PROBE = 2'h1;
   localparam logic [IR_W-1:0] IR_CHECKSUM = 2'h2;
   localparam logic [IR_W-1:0] IR_BYPASS = 2'h3;
   localparam logic [IR_W-1:0] IR_CAPTURE = 2'h1;
   localparam logic [IR_W-1:0] IR_RESET = 2'h3;

   // ----------------------------------------------------------------
   // Sizes and pin lanes
   // ----------------------------------------------------------------
   localparam int PROBES_MAX = 4;
   localparam int PROBES_DEF = 4;
   localparam int SEL_W_DEF = 4;
   localparam int CK_W_DEF = 16;
   localparam int PIN_TDI = 0;
   localparam int PIN_TCK = 1;
   localparam int PIN_TDO = 2;
   localparam int AUX_SERIAL_IN = 0;
   localparam int AUX_SHIFT_CLOCK = 1;
   localparam logic SCAN_ACTIVE_RST = 1'b0;
   localparam logic TDO_RST = 1'b0;

   // ----------------------------------------------------------------
   // Scan port state machine, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [15:0] {
      TAP_RESET = 16'h0001,
      TAP_IDLE = 16'h0002,
      TAP_SEL_DR = 16'h0004,
      TAP_CAP_DR = 16'h0008,
      TAP_SH_DR = 16'h0010,
      TAP_EX1_DR = 16'h0020,
      TAP_PA_DR = 16'h0040,
      TAP_EX2_DR = 16'h0080,
      TAP_UP_DR = 16'h0100,
      TAP_SEL_IR = 16'h0200,
      TAP_CAP_IR = 16'h0400,
      TAP_SH_IR = 16'h0800,
      TAP_EX1_IR = 16'h1000,
      TAP_PA_IR = 16'h2000,
      TAP_EX2_IR = 16'h4000,
      TAP_UP_IR = 16'h8000
   } pjm_tap_t;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] o;
      logic [2:0] oe;
   } pjm_scan_drv_t;

   typedef struct packed {
      logic [PROBES_MAX-1:0] o;
      logic [PROBES_MAX-1:0] oe;
   } pjm_probe_drv_t;

   typedef struct packed {
      logic [1:0] o;
      logic [1:0] oe;
   } pjm_aux_drv_t;

   typedef struct packed {
      logic scan_owns;
      logic scan_active;
      logic probe_on;
      logic secured;
   } pjm_status_t;

endpackage : pjm_pkg

// file: pjm_tap_fsm.sv
module pjm_tap_fsm
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tms_i,
   output pjm_pkg::pjm_tap_t state_o
);
   import pjm_pkg::*;

   pjm_tap_t next_state;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         state_o <= TAP_RESET;
      else
         state_o <= next_state;
   end

   always_comb
   begin
      next_state = TAP_RESET;
      case (state_o)
         TAP_RESET: next_state = tms_i ? TAP_RESET : TAP_IDLE;
         TAP_IDLE: next_state = tms_i ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: next_state = tms_i ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: next_state = tms_i ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR: next_state = tms_i ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: next_state = tms_i ? TAP_UP_DR : TAP_PA_DR;
         TAP_PA_DR: next_state = tms_i ? TAP_EX2_DR : TAP_PA_DR;
         TAP_EX2_DR: next_state = tms_i ? TAP_UP_DR : TAP_SH_DR;
         TAP_UP_DR: next_state = tms_i ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: next_state = tms_i ? TAP_RESET : TAP_CAP_IR;
         TAP_CAP_IR: next_state = tms_i ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR: next_state = tms_i ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: next_state = tms_i ? TAP_UP_IR : TAP_PA_IR;
         TAP_PA_IR: next_state = tms_i ? TAP_EX2_IR : TAP_PA_IR;
         TAP_EX2_IR: next_state = tms_i ? TAP_UP_IR : TAP_SH_IR;
         TAP_UP_IR: next_state = tms_i ? TAP_SEL_DR : TAP_IDLE;
         default: next_state = TAP_RESET;
      endcase
   end

endmodule : pjm_tap_fsm

// file: pjm_probe_pin_mux_chk.sv
module pjm_probe_pin_mux_chk
#(
   parameter int NUM_PROBES = 4
)
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic trst_n_i,
   input wire logic cfg_dedicated_i,
   input wire logic fuse_secure_i,
   input wire logic tms_i,
   input wire logic scan_clk_i,
   input wire logic [2:0] scan_pin_oe_o,
   input wire logic [NUM_PROBES-1:0] probe_out_oe_o,
   input wire logic tms_pullup_en_o,
   input wire logic tdi_pullup_en_o,
   input wire pjm_pkg::pjm_scan_drv_t user_scan_i,
   input wire pjm_pkg::pjm_probe_drv_t user_probe_i,
   input wire pjm_pkg::pjm_status_t status_o
);
   import pjm_pkg::*;
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_user_mode;
      (!tms_i && $stable(user_probe_i))[*5];
   endsequence
   sequence s_user_scan;
      (!cfg_dedicated_i && !tms_i && !scan_clk_i && !status_o.scan_owns
         && $stable(user_scan_i))[*6];
   endsequence
   a_dedicated_pullups: assert property (
      cfg_dedicated_i[*5] |-> tms_pullup_en_o && tdi_pullup_en_o)
      else $error("pull-ups off in dedicated mode");
   a_dedicated_pins: assert property (
      cfg_dedicated_i[*5] |-> status_o.scan_owns && scan_pin_oe_o[1:0] == 2'h0)
      else $error("scan pins not reserved");
   a_flex_pullups: assert property (
      (!cfg_dedicated_i)[*5] |-> !tms_pullup_en_o && !tdi_pullup_en_o)
      else $error("pull-ups on in flexible mode");
   a_user_scan: assert property (
      s_user_scan |-> scan_pin_oe_o == user_scan_i.oe)
      else $error("scan pins not user driven");
   a_claim_pins: assert property (
      $rose(status_o.scan_active) |-> scan_pin_oe_o[1:0] == 2'h0)
      else $error("claimed pins still driven");
   a_user_probe: assert property (
      s_user_mode |-> probe_out_oe_o == user_probe_i.oe[NUM_PROBES-1:0])
      else $error("probe pins not user driven");
   a_probe_drive: assert property (
      (tms_i && trst_n_i && !fuse_secure_i)[*5] |-> &probe_out_oe_o)
      else $error("probe outputs not driven");
   a_secured_off: assert property (
      (tms_i && fuse_secure_i)[*5] |-> probe_out_oe_o == '0)
      else $error("probe driven while secured");
   a_trst_off: assert property (
      (tms_i && !trst_n_i)[*5] |-> probe_out_oe_o == '0)
      else $error("probe driven in test reset");
endmodule : pjm_probe_pin_mux_chk

bind pjm_probe_pin_mux pjm_probe_pin_mux_chk #(.NUM_PROBES(NUM_PROBES)) chk_inst (.mclk_i,
   .rst_i, .trst_n_i, .cfg_dedicated_i, .fuse_secure_i, .tms_i, .scan_clk_i, .scan_pin_oe_o,
   .probe_out_oe_o, .tms_pullup_en_o, .tdi_pullup_en_o, .user_scan_i, .user_probe_i, .status_o);

// file: pjm_probe_model.sv
module pjm_probe_model
(
   input wire logic tdo_i,
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o,
   output logic trst_n_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic tdo_q;
   // ----------------------------------------------------------------
   // Debug instrument, clock rests low between frames
   // ----------------------------------------------------------------
   initial
   begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
      trst_n_o = 1'b1;
   end
   task automatic hold(input logic m, input logic r);
      tms_o = m;
      trst_n_o = r;
   endtask : hold
   task automatic bit_cyc(input logic m, input logic d);
      tms_o = m;
      tdi_o = d;
      #4;
      tck_o = 1'b1;
      tdo_q = tdo_i;
      #7.5;
      tck_o = 1'b0;
      #3.5;
   endtask : bit_cyc
   task automatic to_reset();
      repeat (5) bit_cyc(1'b1, 1'b1);
   endtask : to_reset
   task automatic scan(input logic [1:0] ir, input logic [15:0] dr, output logic [15:0] got);
      for (int i = 0; i < 5; i++)
         bit_cyc(i == 1 || i == 2, 1'b1);
      bit_cyc(1'b0, ir[0]);
      bit_cyc(1'b1, ir[1]);
      for (int i = 0; i < 4; i++)
         bit_cyc(i < 2, 1'b1);
      for (int i = 0; i < 16; i++)
      begin
         bit_cyc(i == 15, dr[i]);
         got[i] = tdo_q;
      end
      bit_cyc(1'b1, 1'b1);
      // Leave Update-DR so the selection commits, then rest in probe mode
      bit_cyc(1'b0, 1'b1);
      tms_o = 1'b1;
   endtask : scan
endmodule : pjm_probe_model

// file: testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import pjm_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_i, cfg_dedicated_i, fuse_secure_i, part_programmed_i, mode_sel_i, tdi;
   logic scan_clk_i, tms_i, trst_n_i, tdo_o;
   wire [8:0] uin;
   logic [2:0] pad, scan_pin_o, scan_pin_oe_o;
   logic [3:0] probe_out_o, probe_out_oe_o;
   logic [1:0] probe_aux_o, probe_aux_oe_o;
   logic [15:0] probe_nets_i, checksum_i;
   logic [23:0] got_v, snap;
   logic [23:0] exp_q[$];
   pjm_scan_drv_t user_scan_i;
   pjm_probe_drv_t user_probe_i;
   pjm_aux_drv_t user_aux_i;
   pjm_status_t status_o;
   logic tms_pu, tdi_pu;
   int num_errors = 0;
   int cmp_count = 0;
   int seed;
   event chk_ev;
   always #5 mclk_i = ~mclk_i;
   assign pad[0] = scan_pin_oe_o[0] ? scan_pin_o[0] : tdi;
   assign pad[1] = scan_pin_oe_o[1] ? scan_pin_o[1] : scan_clk_i;
   assign pad[2] = ~(scan_pin_o[2] ^ scan_pin_oe_o[2]);
   assign snap = {status_o, tms_pu, tdi_pu, scan_pin_oe_o, scan_pin_o & scan_pin_oe_o,
      probe_out_oe_o, probe_out_o & probe_out_oe_o, probe_aux_oe_o, probe_aux_o & probe_aux_oe_o};
   pjm_probe_pin_mux pjm_probe_pin_mux_inst (.mclk_i(mclk_i), .rst_i(rst_i),
      .scan_clk_i(scan_clk_i), .trst_n_i(trst_n_i), .cfg_dedicated_i(cfg_dedicated_i),
      .fuse_secure_i(fuse_secure_i), .part_programmed_i(part_programmed_i),
      .mode_sel_i(mode_sel_i), .tms_i(tms_i), .scan_pin_i(pad), .scan_pin_o(scan_pin_o),
      .scan_pin_oe_o(scan_pin_oe_o), .probe_out_i(~(probe_out_o ^ probe_out_oe_o)),
      .probe_out_o(probe_out_o), .probe_out_oe_o(probe_out_oe_o),
      .probe_aux_i(~(probe_aux_o ^ probe_aux_oe_o)), .probe_aux_o(probe_aux_o),
      .probe_aux_oe_o(probe_aux_oe_o), .checksum_serial_out_o(tdo_o), .tms_pullup_en_o(tms_pu),
      .tdi_pullup_en_o(tdi_pu), .probe_nets_i(probe_nets_i), .checksum_i(checksum_i),
      .user_scan_i(user_scan_i), .user_probe_i(user_probe_i), .user_aux_i(user_aux_i),
      .user_scan_in_o(uin[8:6]), .user_probe_in_o(uin[5:2]), .user_aux_in_o(uin[1:0]),
      .status_o(status_o));
   pjm_probe_model model_inst (.tdo_i(pad[2]), .tck_o(scan_clk_i), .tms_o(tms_i),
      .tdi_o(tdi), .trst_n_o(trst_n_i));
   // ----------------------------------------------------------------
   // Expected values queue, checked by the monitor
   // ----------------------------------------------------------------
   function automatic logic [23:0] want(input logic [5:0] st, input pjm_scan_drv_t s,
      input pjm_probe_drv_t p, input pjm_aux_drv_t a);
      return {st, s.oe, s.o & s.oe, p.oe, p.o & p.oe, a.oe, a.o & a.oe};
   endfunction : want
   task automatic chk(input logic [23:0] e, input logic [23:0] g);
      exp_q.push_back(e);
      got_v = g;
      -> chk_ev;
      #1;
   endtask : chk
   task automatic look(input logic [23:0] e);
      @(negedge mclk_i);
      chk(e, snap);
      @(posedge mclk_i);
   endtask : look
   task automatic results();
      $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results
   initial
   begin : monitor
      logic [23:0] e;
      forever
      begin
         @(chk_ev);
         e = exp_q.pop_front();
         cmp_count++;
         if (got_v !== e)
         begin
            num_errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got_v, e);
         end
      end
   end
   initial
   begin : watchdog
      #200000;
      num_errors++;
      results();
   end
   initial
   begin : main
      logic [15:0] sel, got;
      pjm_scan_drv_t sx;
      pjm_probe_drv_t pv;
      logic [8:0] uexp;
      seed = 8;
      rst_i = 1'b1;
      cfg_dedicated_i = 1'b0;
      fuse_secure_i = 1'b0;
      part_programmed_i = 1'b1;
      mode_sel_i = 1'b0;
      probe_nets_i = 16'($random(seed));
      checksum_i = 16'($random(seed));
      {user_scan_i, user_probe_i, user_aux_i} = 18'($random(seed));
      fork
         model_inst.to_reset();
         repeat (20) @(posedge mclk_i);
      join
      rst_i <= 1'b0;
      model_inst.hold(1'b0, 1'b1);
      repeat (8) @(posedge mclk_i);
      look(want(6'h00, user_scan_i, user_probe_i, user_aux_i));
      uexp = {~(user_scan_i.o[2] ^ user_scan_i.oe[2]), user_scan_i.oe[1] & user_scan_i.o[1],
         user_scan_i.o[0] | ~user_scan_i.oe[0], ~(user_probe_i.o ^ user_probe_i.oe),
         ~(user_aux_i.o ^ user_aux_i.oe)};
      chk(24'(uexp), 24'(uin));
      part_programmed_i <= 1'b0;
      model_inst.bit_cyc(1'b0, 1'b1);
      repeat (8) @(posedge mclk_i);
      look(want(6'h30, '0, user_probe_i, '0));
      part_programmed_i <= 1'b1;
      model_inst.to_reset();
      model_inst.hold(1'b0, 1'b1);
      repeat (8) @(posedge mclk_i);
      look(want(6'h00, user_scan_i, user_probe_i, user_aux_i));
      cfg_dedicated_i <= 1'b1;
      {user_scan_i, user_probe_i, user_aux_i} <= 18'($random(seed));
      repeat (8) @(posedge mclk_i);
      look(want(6'h23, '0, user_probe_i, user_aux_i));
      cfg_dedicated_i <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         probe_nets_i <= 16'($random(seed));
         sel = 16'($random(seed));
         model_inst.scan(IR_PROBE, sel, got);
         repeat (10) @(posedge mclk_i);
         pv.oe = 4'hf;
         for (int k = 0; k < 4; k++)
            pv.o[k] = probe_nets_i[sel[k*4 +: 4]];
         look(want(6'h38, '0, pv, user_aux_i));
      end
      fuse_secure_i <= 1'b1;
      model_inst.scan(IR_PROBE, ~sel, got);
      repeat (10) @(posedge mclk_i);
      look(want(6'h34, '0, '0, user_aux_i));
      model_inst.scan(IR_CHECKSUM, 16'h0001, got);
      chk(24'(checksum_i), 24'(got));
      chk(24'h000001, 24'(tdo_o));
      @(posedge mclk_i);
      fuse_secure_i <= 1'b0;
      repeat (10) @(posedge mclk_i);
      look(want(6'h38, '0, pv, user_aux_i));
      model_inst.hold(1'b1, 1'b0);
      repeat (8) @(posedge mclk_i);
      sx = user_scan_i;
      sx.oe[1:0] = 2'h0;
      look(want(6'h00, sx, '0, user_aux_i));
      model_inst.hold(1'b1, 1'b1);
      results();
   end
endmodule : testbench
